// ===== sim/spx_exec_assertions.sv
// Port-level checker for the push/pop execution core.
`timescale 1ns/100ps
module spx_exec_assertions (
	input wire logic        core_clk,
	input wire logic        rst_b,
	input wire logic        start,
	input wire logic        busy,
	input wire logic        done,
	input wire logic [7:0]  opcode,
	input wire logic        flag_we,
	input wire logic        flag_v,
	input wire logic        mem_re,
	input wire logic        mem_we,
	input wire logic [15:0] mem_addr,
	input wire logic [7:0]  stack_pointer_high_byte,
	input wire logic [7:0]  stack_pointer_low_byte
);
	logic [7:0]  op_reg;
	logic [15:0] sp0_reg;
	wire  [15:0] sp_w = {stack_pointer_high_byte, stack_pointer_low_byte};
	// Opcode and pointer are latched at acceptance so later checks know the context.
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			op_reg  <= 8'h00;
			sp0_reg <= 16'h0000;
		end else if (start && !busy) begin
			op_reg  <= opcode;
			sp0_reg <= sp_w;
		end
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	a_flags_or_only: assert property (flag_we |-> op_reg[7:4] == 4'h4)
		else $error("flag write outside OR");
	a_or_v_clear: assert property (flag_we |-> !flag_v)
		else $error("overflow flag set by OR");
	a_push_addr: assert property (mem_we |-> mem_addr == sp0_reg - 16'h0001)
		else $error("push address wrong");
	a_pop_addr: assert property (mem_re |-> mem_addr == sp0_reg)
		else $error("pop address wrong");
	a_sp_bytes: assert property ((mem_we || mem_re) |-> mem_addr == sp_w)
		else $error("pointer bytes disagree with address");
	a_user_no_mem: assert property (busy && op_reg[7:1] == 7'h49 |-> !mem_re && !mem_we)
		else $error("user pop touched memory");
	a_done_time: assert property ($rose(busy) |-> ##[6:16] done)
		else $error("done late");
	a_done_pulse: assert property (done |=> !done)
		else $error("done longer than one cycle");
	a_push_sp_step: assert property (done && op_reg[7:1] == 7'h38 |=> sp_w == sp0_reg - 16'h0001)
		else $error("push pointer step wrong");
	a_pop_sp_step: assert property (done && op_reg[7:1] == 7'h28 |=> sp_w == sp0_reg + 16'h0001)
		else $error("pop pointer step wrong");
	cover property (mem_we && sp0_reg == 16'h0000);
	cover property (done && op_reg == 8'h93);
	cover property (flag_we);
endmodule : spx_exec_assertions
bind spx_exec spx_exec_assertions spx_exec_assertions_inst (.*);

// ===== sim/spx_store_model.sv
// Register file and stack memory on the far side of the core.
`timescale 1ns/100ps
module spx_store_model (
	input  wire logic        core_clk,
	input  wire logic        rf_re,
	input  wire logic        rf_we,
	input  wire logic [7:0]  rf_addr,
	input  wire logic [7:0]  rf_wdata,
	output logic      [7:0]  rf_rdata,
	input  wire logic        mem_re,
	input  wire logic        mem_we,
	input  wire logic [15:0] mem_addr,
	input  wire logic [7:0]  mem_wdata,
	output logic      [7:0]  mem_rdata
);
	logic [7:0] rf [256];
	logic [7:0] mem [65536];
	// The core registers address and strobe, so read data follows them in the same cycle.
	// Outside the strobe cycle the data is inverted, so a capture at the wrong edge fails.
	assign rf_rdata  = rf_re ? rf[rf_addr] : ~rf[rf_addr];
	assign mem_rdata = mem_re ? mem[mem_addr] : ~mem[mem_addr];
	always @(posedge core_clk) begin
		if (rf_we) rf[rf_addr] <= rf_wdata;
		if (mem_we) mem[mem_addr] <= mem_wdata;
	end
endmodule : spx_store_model

// ===== sim/stack_push_pop_execution_test.sv
// Random and corner-case bench for the push/pop execution core.
`timescale 1ns/100ps
module stack_push_pop_execution_test;
	logic        core_clk = 0, rst_b = 0, start = 0, ext_clock_mode = 0;
	logic [7:0]  opcode = 8'h00, operand_a = 8'h00, operand_b = 8'h00;
	logic        busy, done, flag_we, flag_z, flag_s, flag_v, rf_re, rf_we, mem_re, mem_we;
	logic [7:0]  rf_addr, rf_wdata, mem_wdata, rf_rdata, mem_rdata;
	logic [7:0]  stack_pointer_high_byte, stack_pointer_low_byte;
	logic [15:0] mem_addr, ref_sp = 16'h0000;
	logic [7:0]  ref_rf [256];
	logic [7:0]  ref_mem [65536];
	logic [7:0]  ops [9] = '{8'h44, 8'h45, 8'h46, 8'h50, 8'h51, 8'h70, 8'h71, 8'h92, 8'h93};
	logic        fz, fs;
	int          mismatches = 0, cmp_count = 0, fw = 0;
	spx_exec spx_exec_inst (.*);
	spx_store_model spx_store_model_inst (.*);
	always #2 core_clk = ~core_clk;
	always @(negedge core_clk) begin
		if (flag_we === 1'b1) begin
			{fz, fs} = {flag_z, flag_s};
			fw++;
		end
	end
	// Instruction length from acceptance to done: pushes grow with clock source and indirection.
	function automatic logic [15:0] cycles(logic [7:0] op, logic ext);
		cycles = 16'h000A;
		if (op[7:1] == 7'h38) begin
			cycles = cycles + (ext ? 16'h0002 : 16'h0000) + (op[0] ? 16'h0002 : 16'h0000);
		end
	endfunction : cycles
	task automatic check(string what, logic [15:0] exp, logic [15:0] got);
		cmp_count++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED %s exp %h got %h", what, exp, got);
		end
	endtask : check
	task automatic put(logic [7:0] a, logic [7:0] v);
		ref_rf[a] = v;
		spx_store_model_inst.rf[a] = v;
	endtask : put
	// =====
	// One instruction, then the reference state is stepped and compared: every register, the pointer and any pushed byte.
	task automatic run(logic [7:0] op, logic [7:0] a, logic [7:0] b);
		logic [7:0] p;
		logic       ext;
		int         n;
		p = ref_rf[b];
		ext = 1'($urandom);
		{fz, fs} = 2'bxx;
		fw = 0;
		@(posedge core_clk);
		{start, opcode, operand_a, operand_b} <= {1'b1, op, a, b};
		ext_clock_mode <= ext;
		@(posedge core_clk);
		start <= 1'b0;
		for (n = 0; n < 40 && done !== 1'b1; n++) @(negedge core_clk);
		#1;
		check("cycles", cycles(op, ext), 16'(n - 1));
		check("flag writes", {15'h0000, op[7:4] == 4'h4}, 16'(fw));
		case (op)
			8'h44, 8'h45, 8'h46: begin
				ref_rf[a] = ref_rf[a] | (op == 8'h44 ? p : op == 8'h45 ? ref_rf[p] : b);
				check("flag_z", ref_rf[a] == 8'h00, fz);
				check("flag_s", ref_rf[a][7], fs);
			end
			8'h50, 8'h51: begin
				ref_rf[op[0] ? ref_rf[a] : a] = ref_mem[ref_sp];
				ref_sp = ref_sp + 16'h0001;
			end
			8'h70, 8'h71: begin
				ref_sp = ref_sp - 16'h0001;
				ref_mem[ref_sp] = op[0] ? ref_rf[p] : p;
				check("pushed", ref_mem[ref_sp], spx_store_model_inst.mem[ref_sp]);
			end
			default: begin
				ref_rf[a] = ref_rf[p];
				ref_rf[b] = op[0] ? p + 8'h01 : p - 8'h01;
			end
		endcase
		for (n = 0; n < 256; n++) check("rf", ref_rf[n], spx_store_model_inst.rf[n]);
		check("sp", ref_sp, {stack_pointer_high_byte, stack_pointer_low_byte});
	endtask : run
	task automatic results;
		$display("mismatches %0d of %0d checks", mismatches, cmp_count);
		if (mismatches == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : results
	initial begin
		int i;
		void'($urandom(8));
		for (i = 0; i < 65536; i++) begin
			ref_mem[i] = 8'($urandom);
			spx_store_model_inst.mem[i] = ref_mem[i];
			if (i < 256) put(8'(i), 8'($urandom));
		end
		repeat (4) @(posedge core_clk);
		rst_b <= 1'b1;
		repeat (3) @(posedge core_clk);
		run(8'h70, 8'h00, 8'h40);
		run(8'h50, 8'h10, 8'h00);
		put(8'h05, 8'h00);
		run(8'h92, 8'h06, 8'h05);
		put(8'h07, 8'hFF);
		run(8'h93, 8'h09, 8'h07);
		run(8'h93, 8'h22, 8'h22);
		put(8'h08, 8'h00);
		run(8'h46, 8'h08, 8'h00);
		for (i = 0; i < 72; i++) run(ops[i % 9], 8'($urandom), 8'($urandom));
		results();
	end
	// About 80 instructions of under 20 cycles each; the margin is generous.
	initial begin
		#60000;
		mismatches++;
		results();
	end
endmodule : stack_push_pop_execution_test

// ===== verilog/spx_consts.svh
// Constants for the stack push/pop execution block.
`ifndef SPX_CONSTS_SVH
`define SPX_CONSTS_SVH
`define SPX_OP_OR_R_R     8'h44
`define SPX_OP_OR_R_IR    8'h45
`define SPX_OP_OR_R_IM    8'h46
`define SPX_OP_POP_R      8'h50
`define SPX_OP_POP_IR     8'h51
`define SPX_OP_PUSH_R     8'h70
`define SPX_OP_PUSH_IR    8'h71
`define SPX_OP_PULL_DOWN  8'h92
`define SPX_OP_PULL_UP    8'h93
`define SPX_CYC_BASE      5'h0A
`define SPX_CYC_EXT_EXTRA 5'h02
`define SPX_CYC_IR_EXTRA  5'h02
`define SPX_SP_RESET      16'h0000
`endif

// ===== verilog/spx_exec.sv
// Execution core for OR, push, pop and user-stack pop instructions.
`timescale 1ns/100ps
`include "spx_consts.svh"

module spx_exec (
	input  wire logic        core_clk,
	input  wire logic        rst_b,
	input  wire logic        start,
	input  wire logic [7:0]  opcode,
	input  wire logic [7:0]  operand_a,
	input  wire logic [7:0]  operand_b,
	input  wire logic        ext_clock_mode,
	input  wire logic [7:0]  rf_rdata,
	input  wire logic [7:0]  mem_rdata,
	output logic             busy,
	output logic             done,
	output logic             flag_we,
	output logic             flag_z,
	output logic             flag_s,
	output logic             flag_v,
	output logic             rf_re,
	output logic             rf_we,
	output logic [7:0]       rf_addr,
	output logic [7:0]       rf_wdata,
	output logic             mem_re,
	output logic             mem_we,
	output logic [15:0]      mem_addr,
	output logic [7:0]       mem_wdata,
	output logic [7:0]       stack_pointer_high_byte,
	output logic [7:0]       stack_pointer_low_byte
);
	// ==========================================================
	// Reset synchroniser
	logic              rst_s1_reg;
	logic              rst_s2_reg;
	spx_pkg::spx_state_t state_reg;
	logic [7:0]        op_reg;
	logic [7:0]        a_reg;
	logic [7:0]        b_reg;
	logic [7:0]        ptr_reg;
	logic [7:0]        data_reg;
	logic [4:0]        cyc_reg;
	logic [4:0]        cyc_target_reg;
	logic [15:0]       sp_reg;
	logic [7:0]        or_res;

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			rst_s1_reg <= 1'b0;
			rst_s2_reg <= 1'b0;
		end else begin
			rst_s1_reg <= 1'b1;
			rst_s2_reg <= rst_s1_reg;
		end
	end

	// ==========================================================
	// Decode helpers
	function automatic logic is_user_pop(input logic [7:0] op);
		is_user_pop = (op == `SPX_OP_PULL_DOWN) || (op == `SPX_OP_PULL_UP);
	endfunction : is_user_pop

	function automatic logic is_known(input logic [7:0] op);
		is_known = (op == `SPX_OP_OR_R_R) || (op == `SPX_OP_OR_R_IR) ||
			(op == `SPX_OP_OR_R_IM) || (op == `SPX_OP_POP_R) ||
			(op == `SPX_OP_POP_IR) || (op == `SPX_OP_PUSH_R) ||
			(op == `SPX_OP_PUSH_IR) || is_user_pop(op);
	endfunction : is_known

	// Indirect source forms need an extra register read to fetch the pointer.
	function automatic logic src_indirect(input logic [7:0] op);
		src_indirect = (op == `SPX_OP_OR_R_IR) || (op == `SPX_OP_PUSH_IR) || is_user_pop(op);
	endfunction : src_indirect

	assign or_res = data_reg | rf_rdata;

	// ==========================================================
	// Sequencer
	always_ff @(posedge core_clk or negedge rst_s2_reg) begin
		if (!rst_s2_reg) begin
			state_reg      <= spx_pkg::SPX_IDLE;
			op_reg         <= 8'h00;
			a_reg          <= 8'h00;
			b_reg          <= 8'h00;
			ptr_reg        <= 8'h00;
			data_reg       <= 8'h00;
			cyc_reg        <= 5'h00;
			cyc_target_reg <= 5'h00;
			sp_reg         <= `SPX_SP_RESET;
			busy           <= 1'b0;
			done           <= 1'b0;
			flag_we        <= 1'b0;
			flag_z         <= 1'b0;
			flag_s         <= 1'b0;
			flag_v         <= 1'b0;
			rf_re          <= 1'b0;
			rf_we          <= 1'b0;
			rf_addr        <= 8'h00;
			rf_wdata       <= 8'h00;
			mem_re         <= 1'b0;
			mem_we         <= 1'b0;
			mem_addr       <= 16'h0000;
			mem_wdata      <= 8'h00;
		end else begin
			done    <= 1'b0;
			flag_we <= 1'b0;
			rf_re   <= 1'b0;
			rf_we   <= 1'b0;
			mem_re  <= 1'b0;
			mem_we  <= 1'b0;
			if (state_reg != spx_pkg::SPX_IDLE) begin
				cyc_reg <= cyc_reg + 5'h01;
			end
			case (state_reg)
				spx_pkg::SPX_IDLE: begin
					if (start && is_known(opcode)) begin
						op_reg  <= opcode;
						a_reg   <= operand_a;
						b_reg   <= operand_b;
						busy    <= 1'b1;
						cyc_reg <= 5'h01;
						if (opcode == `SPX_OP_PUSH_R || opcode == `SPX_OP_PUSH_IR) begin
							cyc_target_reg <= `SPX_CYC_BASE
								+ (ext_clock_mode ? `SPX_CYC_EXT_EXTRA : 5'h00)
								+ (opcode == `SPX_OP_PUSH_IR ? `SPX_CYC_IR_EXTRA : 5'h00);
						end else begin
							cyc_target_reg <= `SPX_CYC_BASE;
						end
						state_reg <= spx_pkg::SPX_FETCH;
					end
				end
				spx_pkg::SPX_FETCH: begin
					// Operand b is the source/pointer for pushes and user pops.
					rf_re     <= 1'b1;
					rf_addr   <= (op_reg == `SPX_OP_POP_R || op_reg == `SPX_OP_POP_IR)
						? a_reg : (src_indirect(op_reg) ? b_reg : b_reg);
					state_reg <= src_indirect(op_reg) ? spx_pkg::SPX_ADDR
						: spx_pkg::SPX_READ;
					if (op_reg == `SPX_OP_POP_R || op_reg == `SPX_OP_POP_IR) begin
						mem_re    <= 1'b1;
						mem_addr  <= sp_reg;
						rf_re     <= (op_reg == `SPX_OP_POP_IR);
						state_reg <= spx_pkg::SPX_READ;
					end else if (op_reg == `SPX_OP_PUSH_R || op_reg == `SPX_OP_PUSH_IR) begin
						sp_reg <= sp_reg - 16'h0001;
					end
				end
				spx_pkg::SPX_ADDR: begin
					// Pointer register value returned; now read what it names.
					ptr_reg   <= rf_rdata;
					rf_re     <= 1'b1;
					rf_addr   <= rf_rdata;
					state_reg <= spx_pkg::SPX_READ;
				end
				spx_pkg::SPX_READ: begin
					if (op_reg == `SPX_OP_POP_R) begin
						data_reg <= mem_rdata;
						ptr_reg  <= a_reg;
					end else if (op_reg == `SPX_OP_POP_IR) begin
						data_reg <= mem_rdata;
						ptr_reg  <= rf_rdata;
					end else if (op_reg == `SPX_OP_OR_R_IM) begin
						data_reg <= b_reg;
					end else begin
						data_reg <= rf_rdata;
					end
					// OR needs the destination value too.
					rf_re     <= 1'b1;
					rf_addr   <= a_reg;
					state_reg <= spx_pkg::SPX_WRITE;
				end
				spx_pkg::SPX_WRITE: begin
					state_reg <= spx_pkg::SPX_PTR;
					if (op_reg == `SPX_OP_OR_R_R || op_reg == `SPX_OP_OR_R_IR ||
						op_reg == `SPX_OP_OR_R_IM) begin
						rf_we    <= 1'b1;
						rf_addr  <= a_reg;
						rf_wdata <= or_res;
						flag_we  <= 1'b1;
						flag_z   <= (or_res == 8'h00);
						flag_s   <= or_res[7];
						flag_v   <= 1'b0;
					end else if (op_reg == `SPX_OP_PUSH_R || op_reg == `SPX_OP_PUSH_IR) begin
						mem_we    <= 1'b1;
						mem_addr  <= sp_reg;
						mem_wdata <= data_reg;
					end else begin
						rf_we    <= 1'b1;
						rf_addr  <= (op_reg == `SPX_OP_POP_IR) ? ptr_reg : a_reg;
						rf_wdata <= data_reg;
					end
				end
				spx_pkg::SPX_PTR: begin
					state_reg <= spx_pkg::SPX_WAIT;
					if (op_reg == `SPX_OP_POP_R || op_reg == `SPX_OP_POP_IR) begin
						sp_reg <= sp_reg + 16'h0001;
					end else if (is_user_pop(op_reg)) begin
						rf_we    <= 1'b1;
						rf_addr  <= b_reg;
						rf_wdata <= (op_reg == `SPX_OP_PULL_DOWN) ? ptr_reg - 8'h01
							: ptr_reg + 8'h01;
					end
				end
				spx_pkg::SPX_WAIT: begin
					// Pad to the documented instruction length.
					if (cyc_reg >= cyc_target_reg - 5'h01) begin
						state_reg <= spx_pkg::SPX_DONE;
					end
				end
				spx_pkg::SPX_DONE: begin
					busy      <= 1'b0;
					done      <= 1'b1;
					state_reg <= spx_pkg::SPX_IDLE;
				end
				default: begin
					state_reg <= spx_pkg::SPX_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge rst_s2_reg) begin
		if (!rst_s2_reg) begin
			stack_pointer_high_byte <= 8'h00;
			stack_pointer_low_byte  <= 8'h00;
		end else begin
			stack_pointer_high_byte <= sp_reg[15:8];
			stack_pointer_low_byte  <= sp_reg[7:0];
		end
	end
endmodule : spx_exec

// ===== verilog/spx_pkg.sv
// Types for the stack push/pop execution block.
package spx_pkg;
	typedef enum logic [2:0] {
		SPX_IDLE  = 3'b000,
		SPX_FETCH = 3'b001,
		SPX_ADDR  = 3'b010,
		SPX_READ  = 3'b011,
		SPX_WRITE = 3'b100,
		SPX_PTR   = 3'b101,
		SPX_WAIT  = 3'b110,
		SPX_DONE  = 3'b111
	} spx_state_t;
endpackage : spx_pkg
